// *** hdl/ebc_pkg.sv ***
// Shared constants, parameter indices, commands and carrier types of the ejector command block.
// Assumes a single 40 MHz clock and parameter access by 16-bit index.
package ebc_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYC = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [15:0] IDX_SYS_CMD = 16'h0002;
  localparam logic [15:0] IDX_BLOW_MODE = 16'h0045;
  localparam logic [15:0] IDX_SIG_TYPE = 16'h0049;
  localparam logic [15:0] IDX_OUT_FILTER = 16'h004B;
  localparam logic [15:0] IDX_LOCKS = 16'h005A;
  localparam logic [15:0] IDX_NFC_PIN = 16'h005B;
  localparam logic [15:0] IDX_PROF0_DUR = 16'h006A;
  localparam logic [15:0] PROF_STRIDE = 16'h0100;
  localparam int PROF_W = 2;

  localparam logic [7:0] CMD_APP_RESET = 8'h81;
  localparam logic [7:0] CMD_FULL_RESTORE = 8'h83;
  localparam logic [7:0] CMD_ZERO_CAL = 8'hA5;
  localparam logic [7:0] CMD_CLR_CNT = 8'hA7;
  localparam logic [7:0] CMD_CLR_VOLT = 8'hA8;
  localparam logic [7:0] CMD_CLR_VAC = 8'hA9;

  localparam logic [15:0] DUR_MIN = 16'h000A;
  localparam logic [15:0] DUR_MAX = 16'h270F;
  localparam logic [15:0] FILT_MAX = 16'h03E7;
  localparam logic [15:0] PIN_MAX = 16'h03E7;
  localparam logic [15:0] DUR_DEF = 16'h0000;
  localparam logic [15:0] FILT_DEF = 16'h0000;
  localparam logic [15:0] PIN_DEF = 16'h0000;
  localparam logic [7:0] LOCK_DEF = 8'h00;
  localparam logic [7:0] SIG_DEF = 8'h00;
  localparam logic [7:0] MODE_DEF = 8'h00;
  localparam logic [7:0] MODE_MAX = 8'h02;

  localparam int LOCK_NFC_WR_BIT = 0;
  localparam int LOCK_NFC_OFF_BIT = 1;
  localparam int LOCK_EVT_BIT = 4;
  localparam int SIG_OUT_INV_BIT = 0;
  localparam int SIG_IN_INV_BIT = 1;
  localparam int SIG_NC_BIT = 2;

  localparam logic [7:0] SETMODE_OFF = 8'h00;
  localparam logic [7:0] SETMODE_ON = 8'h01;

  localparam int ZERO_PCT = 3;
  localparam int PCT_FULL = 100;

  typedef enum logic [1:0] {BLOW_EXT, BLOW_INT_TIMED, BLOW_EXT_TIMED} ebc_blow_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] idx;
    logic [15:0] data;
  } ebc_par_req_t;

  typedef struct packed {
    logic wr;
    logic [15:0] idx;
    logic [15:0] data;
    logic [15:0] pin;
  } ebc_nfc_req_t;

  typedef struct packed {
    logic suction;
    logic blowoff;
    logic [7:0] set_mode;
    logic [PROF_W-1:0] profile;
  } ebc_pd_out_t;

endpackage

// *** hdl/ebc_ms_tick.sv ***
// One-millisecond tick divider for the ejector command block.
// Assumes one free-running clock; the tick is a one-cycle enable.
`timescale 1ns/1ps
`default_nettype none
module ebc_ms_tick
  import ebc_pkg::*;
#(
  parameter int CYCLES = TICK_CYC
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  output logic o_tick
);

  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  initial
  begin
    if (CYCLES < 1)
      $error("ebc_ms_tick: CYCLES must be at least one");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic tick_nxt;

  always_comb
  begin
    tick_nxt = (cnt_r == LAST);
    cnt_nxt = tick_nxt ? '0 : cnt_r + 1'b1;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cnt_r <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      o_tick <= tick_nxt;
    end
  end

endmodule
`default_nettype wire

// *** hdl/ebc_top.sv ***
// Ejector blow-off, operating mode, system command, access lock and output filter control.
// Assumes parameter requests and process data come from the same clock domain; SIO pins do not.
//
// What this block does
// - External mode: blow while blow command held.
// - Internal timed: blow set time after suction off.
// - External timed: rising command, fixed duration, no extension.
// - Blow duration accepted from 10 to 9999 ms.
// - Zero duration forces external blow-off mode.
// - Separate duration per profile, profile zero 0x006A.
// - Automatic mode entered directly after power-up.
// - Setting mode disables valve protection monitoring.
// - Setting mode left on bit change or request.
// - 0x81 resets application parameters, link stays up.
// - 0x83 restores settings, stops link, needs restart.
// - Full restore keeps counters, zero point, extremes.
// - 0xA5 zero calibration within three percent only.
// - 0xA8 clears supply voltage minimum and maximum.
// - 0xA9 clears vacuum minimum and maximum.
// - Lock bits: NFC write, NFC off, events.
// - Nonzero PIN rejects NFC writes without match.
// - PIN defaults to zero, set only over link.
// - Part-present switch-off delay 1 to 999 ms.
// - Normally closed output turns delay into switch-on.
// - Blow-off mode selected by index 0x0045.
// - Blow-off wins over suction, even when long.
`timescale 1ns/1ps
`default_nettype none
module ebc_top
  import ebc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int NPROF = 4,
  parameter int VAC_W = 12,
  parameter int VAC_FULL = 1000
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_iol_mode,
  input wire ebc_par_req_t i_par,
  input wire ebc_nfc_req_t i_nfc,
  input wire ebc_pd_out_t i_pd,
  input wire logic i_sio_suction,
  input wire logic i_sio_blowoff,
  input wire logic i_part_present_raw,
  input wire logic signed [VAC_W-1:0] i_vacuum,
  output logic o_par_ack,
  output logic [15:0] o_par_rdata,
  output logic o_nfc_ack,
  output logic o_nfc_rejected,
  output logic o_suction_valve,
  output logic o_blow_valve,
  output logic o_part_present_output,
  output logic o_pd_part_present,
  output logic o_setting_mode,
  output logic o_valve_protect_en,
  output logic o_iol_comm_en,
  output logic o_nfc_enable,
  output logic o_iol_event_en,
  output logic o_restart_required,
  output logic o_clr_erasable_cnt,
  output logic o_clr_volt_minmax,
  output logic o_clr_vac_minmax,
  output logic signed [VAC_W-1:0] o_zero_offset,
  output logic o_zero_limit_err
);

  initial
  begin
    if (NPROF < 1 || NPROF > (1 << PROF_W))
      $error("ebc_top: NPROF out of range");
    if (VAC_W < 2 || VAC_FULL < 1)
      $error("ebc_top: vacuum range unusable");
  end

  localparam logic signed [VAC_W-1:0] ZERO_LIM = VAC_W'((VAC_FULL * ZERO_PCT) / PCT_FULL);

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and pin synchronisers.

  logic tick;

  ebc_ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .o_tick(tick)
  );

  logic [1:0] sync_suc_r;
  logic [1:0] sync_blow_r;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sync_suc_r <= 2'b00;
      sync_blow_r <= 2'b00;
    end
    else
    begin
      sync_suc_r <= {sync_suc_r[0], i_sio_suction};
      sync_blow_r <= {sync_blow_r[0], i_sio_blowoff};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter store and system commands.

  logic [15:0] dur_r [NPROF];
  logic [15:0] dur_nxt [NPROF];
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] sig_r, sig_nxt;
  logic [15:0] filt_r, filt_nxt;
  logic [7:0] lock_r, lock_nxt;
  logic [15:0] pin_r, pin_nxt;
  logic halted_r, halted_nxt;
  logic restart_r, restart_nxt;
  logic ack_nxt, nfc_ack_nxt, nfc_rej_nxt;
  logic [15:0] rdata_nxt;
  logic clr_cnt_nxt, clr_volt_nxt, clr_vac_nxt;
  logic signed [VAC_W-1:0] zoff_nxt;
  logic zerr_nxt;
  logic w_en;
  logic [15:0] w_idx, w_data;
  logic nfc_ok;

  always_comb
  begin
    dur_nxt = dur_r;
    mode_nxt = mode_r;
    sig_nxt = sig_r;
    filt_nxt = filt_r;
    lock_nxt = lock_r;
    pin_nxt = pin_r;
    halted_nxt = halted_r;
    restart_nxt = restart_r;
    ack_nxt = 1'b0;
    rdata_nxt = o_par_rdata;
    clr_cnt_nxt = 1'b0;
    clr_volt_nxt = 1'b0;
    clr_vac_nxt = 1'b0;
    zoff_nxt = o_zero_offset;
    zerr_nxt = o_zero_limit_err;
    // Link requests win the shared write path; a colliding NFC write is refused rather than lost silently.
    nfc_ok = i_nfc.wr && !i_par.wr && !lock_r[LOCK_NFC_WR_BIT] && !lock_r[LOCK_NFC_OFF_BIT]
             && (pin_r == PIN_DEF || i_nfc.pin == pin_r) && i_nfc.idx != IDX_NFC_PIN
             && i_nfc.idx != IDX_SYS_CMD;
    nfc_ack_nxt = i_nfc.wr && !lock_r[LOCK_NFC_OFF_BIT];
    nfc_rej_nxt = i_nfc.wr && !lock_r[LOCK_NFC_OFF_BIT] && !nfc_ok;
    w_en = (i_par.wr && !halted_r) || nfc_ok;
    w_idx = i_par.wr ? i_par.idx : i_nfc.idx;
    w_data = i_par.wr ? i_par.data : i_nfc.data;
    if (i_par.rd && !halted_r)
    begin
      ack_nxt = 1'b1;
      rdata_nxt = '0;
      unique case (i_par.idx)
        IDX_BLOW_MODE: rdata_nxt = {8'h00, mode_r};
        IDX_SIG_TYPE: rdata_nxt = {8'h00, sig_r};
        IDX_OUT_FILTER: rdata_nxt = filt_r;
        IDX_LOCKS: rdata_nxt = {8'h00, lock_r};
        IDX_NFC_PIN: rdata_nxt = pin_r;
        default:
        begin
          for (int p = 0; p < NPROF; p++)
            if (i_par.idx == IDX_PROF0_DUR + 16'(p) * PROF_STRIDE)
              rdata_nxt = dur_r[p];
        end
      endcase
    end
    if (i_par.wr && !halted_r)
      ack_nxt = 1'b1;
    if (w_en)
    begin
      unique case (w_idx)
        IDX_BLOW_MODE: if (w_data[7:0] <= MODE_MAX) mode_nxt = w_data[7:0];
        IDX_SIG_TYPE: sig_nxt = w_data[7:0];
        IDX_OUT_FILTER: if (w_data <= FILT_MAX) filt_nxt = w_data;
        IDX_LOCKS: lock_nxt = w_data[7:0];
        IDX_NFC_PIN: if (w_data <= PIN_MAX) pin_nxt = w_data;
        IDX_SYS_CMD:
        begin
          unique case (w_data[7:0])
            CMD_APP_RESET, CMD_FULL_RESTORE:
            begin
              for (int p = 0; p < NPROF; p++)
                dur_nxt[p] = DUR_DEF;
              mode_nxt = MODE_DEF;
              sig_nxt = SIG_DEF;
              filt_nxt = FILT_DEF;
              lock_nxt = LOCK_DEF;
              pin_nxt = PIN_DEF;
              restart_nxt = 1'b1;
              // Counters, zero point and extremes are deliberately left alone here.
              halted_nxt = (w_data[7:0] == CMD_FULL_RESTORE);
            end
            CMD_ZERO_CAL:
            begin
              if (i_vacuum <= ZERO_LIM && i_vacuum >= -ZERO_LIM)
              begin
                zoff_nxt = i_vacuum;
                zerr_nxt = 1'b0;
              end
              else
                zerr_nxt = 1'b1;
            end
            CMD_CLR_CNT: clr_cnt_nxt = 1'b1;
            CMD_CLR_VOLT: clr_volt_nxt = 1'b1;
            CMD_CLR_VAC: clr_vac_nxt = 1'b1;
            default: ;
          endcase
        end
        default:
        begin
          for (int p = 0; p < NPROF; p++)
            if (w_idx == IDX_PROF0_DUR + 16'(p) * PROF_STRIDE
                && (w_data == 16'h0000 || (w_data >= DUR_MIN && w_data <= DUR_MAX)))
              dur_nxt[p] = w_data;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int p = 0; p < NPROF; p++)
        dur_r[p] <= DUR_DEF;
      mode_r <= MODE_DEF;
      sig_r <= SIG_DEF;
      filt_r <= FILT_DEF;
      lock_r <= LOCK_DEF;
      pin_r <= PIN_DEF;
      halted_r <= 1'b0;
      restart_r <= 1'b0;
      o_par_ack <= 1'b0;
      o_par_rdata <= '0;
      o_nfc_ack <= 1'b0;
      o_nfc_rejected <= 1'b0;
      o_clr_erasable_cnt <= 1'b0;
      o_clr_volt_minmax <= 1'b0;
      o_clr_vac_minmax <= 1'b0;
      o_zero_offset <= '0;
      o_zero_limit_err <= 1'b0;
    end
    else
    begin
      dur_r <= dur_nxt;
      mode_r <= mode_nxt;
      sig_r <= sig_nxt;
      filt_r <= filt_nxt;
      lock_r <= lock_nxt;
      pin_r <= pin_nxt;
      halted_r <= halted_nxt;
      restart_r <= restart_nxt;
      o_par_ack <= ack_nxt;
      o_par_rdata <= rdata_nxt;
      o_nfc_ack <= nfc_ack_nxt;
      o_nfc_rejected <= nfc_rej_nxt;
      o_clr_erasable_cnt <= clr_cnt_nxt;
      o_clr_volt_minmax <= clr_volt_nxt;
      o_clr_vac_minmax <= clr_vac_nxt;
      o_zero_offset <= zoff_nxt;
      o_zero_limit_err <= zerr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode, setting mode and valve control.

  logic cmd_suc, cmd_blow;
  logic prev_suc_r, prev_blow_r, prev_suc_nxt, prev_blow_nxt;
  logic pd_suc_r, pd_blow_r;
  logic set_nxt;
  logic [15:0] bcnt_r, bcnt_nxt;
  logic [15:0] act_dur;
  ebc_blow_mode_t eff_mode;
  logic blow_nxt, suc_nxt;

  always_comb
  begin
    cmd_suc = i_iol_mode ? i_pd.suction : (sync_suc_r[1] ^ sig_r[SIG_IN_INV_BIT]);
    cmd_blow = i_iol_mode ? i_pd.blowoff : (sync_blow_r[1] ^ sig_r[SIG_IN_INV_BIT]);
    act_dur = (32'(i_pd.profile) < NPROF) ? dur_r[i_pd.profile] : dur_r[0];
    eff_mode = ebc_blow_mode_t'(mode_r[1:0]);
    if (act_dur == 16'h0000)
      eff_mode = BLOW_EXT;
    prev_suc_nxt = cmd_suc;
    prev_blow_nxt = cmd_blow;
    set_nxt = o_setting_mode;
    if (!i_iol_mode || i_pd.set_mode == SETMODE_OFF
        || i_pd.suction != pd_suc_r || i_pd.blowoff != pd_blow_r)
      set_nxt = 1'b0;
    else if (i_pd.set_mode == SETMODE_ON)
      set_nxt = 1'b1;
    bcnt_nxt = bcnt_r;
    if (tick && bcnt_r != 16'h0000)
      bcnt_nxt = bcnt_r - 16'h0001;
    unique case (eff_mode)
      BLOW_EXT: bcnt_nxt = 16'h0000;
      BLOW_INT_TIMED: if (prev_suc_r && !cmd_suc) bcnt_nxt = act_dur;
      BLOW_EXT_TIMED: if (!prev_blow_r && cmd_blow) bcnt_nxt = act_dur;
      default: bcnt_nxt = 16'h0000;
    endcase
    // A held command does not reload the counter, so in external timed mode a long level cannot stretch the blow.
    blow_nxt = (eff_mode == BLOW_EXT_TIMED) ? (bcnt_nxt != 16'h0000)
               : (cmd_blow || bcnt_nxt != 16'h0000);
    suc_nxt = cmd_suc && !blow_nxt;
    if (halted_r)
    begin
      blow_nxt = 1'b0;
      suc_nxt = 1'b0;
      bcnt_nxt = 16'h0000;
    end
  end

  // Automatic mode needs no entry command: valves follow commands from the first cycle after reset.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      prev_suc_r <= 1'b0;
      prev_blow_r <= 1'b0;
      pd_suc_r <= 1'b0;
      pd_blow_r <= 1'b0;
      bcnt_r <= 16'h0000;
      o_setting_mode <= 1'b0;
      o_valve_protect_en <= 1'b1;
      o_blow_valve <= 1'b0;
      o_suction_valve <= 1'b0;
      o_iol_comm_en <= 1'b1;
      o_nfc_enable <= 1'b1;
      o_iol_event_en <= 1'b1;
      o_restart_required <= 1'b0;
    end
    else
    begin
      prev_suc_r <= prev_suc_nxt;
      prev_blow_r <= prev_blow_nxt;
      pd_suc_r <= i_pd.suction;
      pd_blow_r <= i_pd.blowoff;
      bcnt_r <= bcnt_nxt;
      o_setting_mode <= set_nxt;
      o_valve_protect_en <= !set_nxt;
      o_blow_valve <= blow_nxt;
      o_suction_valve <= suc_nxt;
      o_iol_comm_en <= !halted_nxt;
      o_nfc_enable <= !lock_nxt[LOCK_NFC_OFF_BIT];
      o_iol_event_en <= !lock_nxt[LOCK_EVT_BIT];
      o_restart_required <= restart_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Part-present filter.

  logic pp_r, pp_nxt;
  logic [15:0] fcnt_r, fcnt_nxt;
  logic delayed_dir;

  always_comb
  begin
    pp_nxt = pp_r;
    fcnt_nxt = fcnt_r;
    // Normally open delays the falling edge, normally closed the rising edge.
    delayed_dir = sig_r[SIG_NC_BIT] ? i_part_present_raw : !i_part_present_raw;
    if (i_part_present_raw == pp_r || filt_r == 16'h0000 || !delayed_dir)
    begin
      pp_nxt = i_part_present_raw;
      fcnt_nxt = filt_r;
    end
    else if (tick)
    begin
      if (fcnt_r <= 16'h0001)
        pp_nxt = i_part_present_raw;
      else
        fcnt_nxt = fcnt_r - 16'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pp_r <= 1'b0;
      fcnt_r <= 16'h0000;
      o_pd_part_present <= 1'b0;
      o_part_present_output <= 1'b0;
    end
    else
    begin
      pp_r <= pp_nxt;
      fcnt_r <= fcnt_nxt;
      o_pd_part_present <= pp_nxt;
      o_part_present_output <= pp_nxt ^ sig_r[SIG_NC_BIT] ^ sig_r[SIG_OUT_INV_BIT];
    end
  end

endmodule
`default_nettype wire

// *** bench/ebc_host_model.sv ***
// Controller model that issues parameter requests and output process data.
// Assumes callers act at the falling edge, one request at a time.
`timescale 1ns/1ps
`default_nettype none
module ebc_host_model
  import ebc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_ack,
  input wire logic [15:0] i_rdata,
  output var ebc_par_req_t o_par,
  output var ebc_pd_out_t o_pd
);
  int n_err;

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_err = 0;
    o_par = '0;
    o_pd = '0;
  end

  // Released index and data lines show inverted values and both strobes drop, so stale data never looks valid.
  task automatic req(input logic wr, input logic [15:0] idx, input logic [15:0] d, output logic [15:0] q);
    int k;
    @(negedge i_clk);
    o_par = {wr, !wr, idx, d};
    @(negedge i_clk);
    o_par = {2'h0, ~idx, ~d};
    for (k = 0; k < 4 && i_ack !== 1'b1; k++)
      @(negedge i_clk);
    if (i_ack !== 1'b1)
      n_err++;
    q = i_rdata;
  endtask

  task automatic setpd(input ebc_pd_out_t v);
    @(negedge i_clk);
    o_pd = v;
  endtask
endmodule
`default_nettype wire

// *** bench/ebc_top_asserts.sv ***
// Port-level checker of the ejector command block.
// Assumes one clock domain and single-cycle parameter requests.
`timescale 1ns/1ps
`default_nettype none
module ebc_top_asserts
  import ebc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire ebc_par_req_t i_par,
  input wire ebc_nfc_req_t i_nfc,
  input wire ebc_pd_out_t i_pd,
  input wire logic o_par_ack,
  input wire logic o_nfc_ack,
  input wire logic o_nfc_rejected,
  input wire logic o_suction_valve,
  input wire logic o_blow_valve,
  input wire logic o_setting_mode,
  input wire logic o_valve_protect_en,
  input wire logic o_iol_comm_en,
  input wire logic o_nfc_enable,
  input wire logic o_restart_required,
  input wire logic o_clr_erasable_cnt,
  input wire logic o_clr_volt_minmax,
  input wire logic o_clr_vac_minmax
);
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  ////////////////////////////////////////////////////////////////////////
  // Command byte taken one cycle ago, to tie each pulse to its cause.
  always_comb
  begin
    cmd_nxt = (i_par.wr && i_par.idx == IDX_SYS_CMD && o_iol_comm_en) ? i_par.data[7:0] : 8'h00;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      cmd_r <= 8'h00;
    else
      cmd_r <= cmd_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  ack_follows_req_a: assert property ((i_par.wr || i_par.rd) && o_iol_comm_en |=> o_par_ack)
    else $error("parameter request not acknowledged");
  ack_needs_req_a: assert property (!(i_par.wr || i_par.rd) |=> !o_par_ack)
    else $error("acknowledge without request");
  halted_no_ack_a: assert property (!o_iol_comm_en |=> !o_par_ack)
    else $error("acknowledge after link stop");
  halt_cause_a: assert property ($fell(o_iol_comm_en) |-> cmd_r == CMD_FULL_RESTORE)
    else $error("link stopped without full restore");
  protect_tracks_a: assert property (o_valve_protect_en != o_setting_mode)
    else $error("valve protection not opposite to setting mode");
  blow_wins_a: assert property (o_blow_valve |-> !o_suction_valve)
    else $error("suction on during blow-off");
  setmode_exit_a: assert property (o_setting_mode && $changed(i_pd.suction) |=> !o_setting_mode)
    else $error("setting mode kept after suction change");
  lock_change_a: assert property ($changed(o_nfc_enable) |-> o_par_ack || o_nfc_ack)
    else $error("contactless enable changed without write");
  nfc_off_a: assert property (!o_nfc_enable && i_nfc.wr |=> !o_nfc_ack)
    else $error("contactless write answered while disabled");
  reject_ack_a: assert property (o_nfc_rejected |-> o_nfc_ack)
    else $error("reject without acknowledge");
  cnt_clear_a: assert property (cmd_r == CMD_CLR_CNT |-> o_clr_erasable_cnt)
    else $error("counter clear pulse missing");
  volt_clear_a: assert property (o_clr_volt_minmax == (cmd_r == CMD_CLR_VOLT))
    else $error("voltage extremes clear pulse wrong");
  vac_clear_a: assert property (o_clr_vac_minmax |-> cmd_r == CMD_CLR_VAC)
    else $error("vacuum extremes clear without command");
  restart_sticky_a: assert property (o_restart_required |=> o_restart_required)
    else $error("restart flag dropped");
endmodule

bind ebc_top ebc_top_asserts u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_par(i_par), .i_nfc(i_nfc),
  .i_pd(i_pd), .o_par_ack(o_par_ack), .o_nfc_ack(o_nfc_ack), .o_nfc_rejected(o_nfc_rejected),
  .o_suction_valve(o_suction_valve), .o_blow_valve(o_blow_valve), .o_setting_mode(o_setting_mode),
  .o_valve_protect_en(o_valve_protect_en), .o_iol_comm_en(o_iol_comm_en), .o_nfc_enable(o_nfc_enable),
  .o_restart_required(o_restart_required), .o_clr_erasable_cnt(o_clr_erasable_cnt),
  .o_clr_volt_minmax(o_clr_volt_minmax), .o_clr_vac_minmax(o_clr_vac_minmax));
`default_nettype wire

// *** bench/ebc_top_test.sv ***
// Self-checking bench of the ejector command block.
// Assumes a 40 MHz clock; the millisecond tick is cut to four cycles.
`timescale 1ns/1ps
`default_nettype none
module ebc_top_test
  import ebc_pkg::*;
;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic iol = 1'b1;
  logic sio_s = 1'b0, sio_b = 1'b0;
  logic raw = 1'b0;
  logic signed [11:0] vac = 12'h000;
  ebc_nfc_req_t nfc = '0;
  ebc_par_req_t par;
  ebc_pd_out_t pd;
  logic ack, nack, nrej, suc, blow, ppo, ppd, setm, vpe, comm, nfce, evte, rreq, c_cnt, c_volt, c_vac, zerr;
  logic [15:0] rdata;
  logic [15:0] q;
  logic signed [11:0] zoff;
  logic [15:0] dv[4] = '{DUR_MAX, 16'h2710, 16'h0009, DUR_MIN};
  logic [15:0] de[4] = '{DUR_MAX, DUR_MAX, DUR_MAX, DUR_MIN};
  logic [15:0] cmds[4] = '{16'h00A7, 16'h00A8, 16'h00A9, 16'h0055};
  int n_pulse[3];
  int n_mismatch = 0;
  int checks_done = 0;
  int e;

  ////////////////////////////////////////////////////////////////////////
  ebc_top #(.TICK_CYCLES(TK)) DUT (.i_clk(clk), .i_sys_rst(rst), .i_iol_mode(iol), .i_par(par), .i_nfc(nfc),
    .i_pd(pd), .i_sio_suction(sio_s), .i_sio_blowoff(sio_b), .i_part_present_raw(raw), .i_vacuum(vac),
    .o_par_ack(ack), .o_par_rdata(rdata), .o_nfc_ack(nack), .o_nfc_rejected(nrej), .o_suction_valve(suc),
    .o_blow_valve(blow), .o_part_present_output(ppo), .o_pd_part_present(ppd), .o_setting_mode(setm),
    .o_valve_protect_en(vpe), .o_iol_comm_en(comm), .o_nfc_enable(nfce), .o_iol_event_en(evte),
    .o_restart_required(rreq), .o_clr_erasable_cnt(c_cnt), .o_clr_volt_minmax(c_volt),
    .o_clr_vac_minmax(c_vac), .o_zero_offset(zoff), .o_zero_limit_err(zerr));
  ebc_host_model HOST (.i_clk(clk), .i_ack(ack), .i_rdata(rdata), .o_par(par), .o_pd(pd));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    n_pulse[0] += int'(c_cnt === 1'b1);
    n_pulse[1] += int'(c_volt === 1'b1);
    n_pulse[2] += int'(c_vac === 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    HOST.req(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [15:0] exp, input string nm);
    HOST.req(1'b0, idx, 16'h0000, q);
    chk(nm, exp, q);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pdset(input logic s, input logic b, input logic [7:0] m, input logic [1:0] p);
    HOST.setpd({s, b, m, p});
  endtask

  // Timed blow-off may end one tick early.
  task automatic blow_len(input int win, input int lo, input int hi);
    int n = 0;
    repeat (win)
    begin
      @(negedge clk);
      n += int'(blow === 1'b1);
    end
    checks_done++;
    if (n < lo || n > hi)
    begin
      n_mismatch++;
      $display("mismatch blow_len expected %0d to %0d seen %0d", lo, hi, n);
    end
  endtask

  task automatic nfc_wr(input logic [15:0] idx, input logic [15:0] pin, input logic a, input logic r);
    @(negedge clk);
    nfc = {1'b1, idx, 16'h0007, pin};
    @(negedge clk);
    nfc = {1'b0, ~idx, 16'hFFF8, ~pin};
    chk("nfc_ack", 16'(a), 16'(nack));
    chk("nfc_rejected", 16'(r), 16'(nrej));
  endtask

  task automatic pp(input int n, input logic e_pd, input logic e_out);
    cyc(n);
    chk("pd_part_present", 16'(e_pd), 16'(ppd));
    chk("part_present_output", 16'(e_out), 16'(ppo));
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    cyc(4);
    rst = 1'b0;
    chk("valve_protect", 16'h0001, 16'(vpe));
    rd(IDX_NFC_PIN, PIN_DEF, "pin_default");
    pdset(1'b1, 1'b0, SETMODE_OFF, 2'h0);
    cyc(2);
    chk("suction", 16'h0001, 16'(suc));
    pdset(1'b1, 1'b1, SETMODE_OFF, 2'h0);
    cyc(100);
    chk("blow_held", 16'h0001, 16'(blow));
    chk("suction_off", 16'h0000, 16'(suc));
    pdset(1'b1, 1'b0, SETMODE_OFF, 2'h0);
    cyc(2);
    chk("blow_end", 16'h0000, 16'(blow));
    iol = 1'b0;
    {sio_s, sio_b} = 2'b11;
    cyc(50);
    chk("sio_blow", 16'h0001, 16'(blow));
    sio_b = 1'b0;
    cyc(5);
    chk("sio_suction", 16'h0001, 16'(suc));
    iol = 1'b1;
    foreach (dv[i])
    begin
      wr(IDX_PROF0_DUR, dv[i]);
      rd(IDX_PROF0_DUR, de[i], "duration");
    end
    wr(IDX_BLOW_MODE, 16'h0002);
    pdset(1'b0, 1'b1, SETMODE_OFF, 2'h0);
    blow_len(80, 9 * TK - 1, 10 * TK + 1);
    pdset(1'b1, 1'b0, SETMODE_OFF, 2'h0);
    wr(IDX_BLOW_MODE, 16'h0001);
    pdset(1'b0, 1'b0, SETMODE_OFF, 2'h0);
    blow_len(80, 9 * TK - 1, 10 * TK + 1);
    wr(IDX_PROF0_DUR + PROF_STRIDE, 16'h0014);
    wr(IDX_BLOW_MODE, 16'h0002);
    pdset(1'b0, 1'b0, SETMODE_OFF, 2'h1);
    pdset(1'b0, 1'b1, SETMODE_OFF, 2'h1);
    blow_len(120, 19 * TK - 1, 20 * TK + 1);
    pdset(1'b0, 1'b0, SETMODE_OFF, 2'h2);
    pdset(1'b0, 1'b1, SETMODE_OFF, 2'h2);
    blow_len(60, 60, 60);
    pdset(1'b0, 1'b0, SETMODE_ON, 2'h0);
    cyc(2);
    chk("setting_mode", 16'h0001, 16'(setm));
    chk("valve_protect_off", 16'h0000, 16'(vpe));
    pdset(1'b1, 1'b0, SETMODE_ON, 2'h0);
    cyc(1);
    chk("setting_exit_bit", 16'h0000, 16'(setm));
    pdset(1'b1, 1'b0, SETMODE_OFF, 2'h0);
    pdset(1'b1, 1'b0, SETMODE_ON, 2'h0);
    pdset(1'b1, 1'b0, SETMODE_OFF, 2'h0);
    cyc(2);
    chk("setting_exit_byte", 16'h0000, 16'(setm));
    wr(IDX_NFC_PIN, 16'h007B);
    nfc_wr(IDX_OUT_FILTER, 16'h0000, 1'b1, 1'b1);
    nfc_wr(IDX_OUT_FILTER, 16'h007B, 1'b1, 1'b0);
    rd(IDX_OUT_FILTER, 16'h0007, "filter");
    nfc_wr(IDX_NFC_PIN, 16'h007B, 1'b1, 1'b1);
    wr(IDX_LOCKS, 16'h0001);
    nfc_wr(IDX_OUT_FILTER, 16'h007B, 1'b1, 1'b1);
    wr(IDX_LOCKS, 16'h0012);
    chk("nfc_enable", 16'h0000, 16'(nfce));
    chk("event_en", 16'h0000, 16'(evte));
    nfc_wr(IDX_OUT_FILTER, 16'h007B, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      wr(IDX_SIG_TYPE, k[0] ? 16'h0004 : 16'h0000);
      raw = 1'b1;
      pp(2, !k[0], 1'b1);
      pp(33, 1'b1, !k[0]);
      raw = 1'b0;
      pp(2, !k[0], 1'b1);
      pp(33, 1'b0, k[0]);
    end
    foreach (cmds[i])
      wr(IDX_SYS_CMD, cmds[i]);
    cyc(2);
    for (int k = 0; k < 3; k++)
      chk("clear_pulses", 16'h0001, 16'(n_pulse[k]));
    chk("restart_unknown", 16'h0000, 16'(rreq));
    rd(IDX_NFC_PIN, 16'h007B, "pin_kept");
    wr(IDX_SYS_CMD, {8'h00, CMD_APP_RESET});
    chk("restart", 16'h0001, 16'(rreq));
    chk("link_kept", 16'h0001, 16'(comm));
    rd(IDX_NFC_PIN, PIN_DEF, "pin_reset");
    vac = 12'h014;
    wr(IDX_SYS_CMD, {8'h00, CMD_ZERO_CAL});
    chk("zero_offset", 16'h0014, 16'(zoff));
    vac = 12'hFD8;
    wr(IDX_SYS_CMD, {8'h00, CMD_ZERO_CAL});
    chk("zero_limit", 16'h0001, 16'(zerr));
    chk("zero_unchanged", 16'h0014, 16'(zoff));
    wr(IDX_SYS_CMD, {8'h00, CMD_FULL_RESTORE});
    chk("link_stopped", 16'h0000, 16'(comm));
    chk("zero_survives", 16'h0014, 16'(zoff));
    chk("host_acks", 16'h0000, 16'(HOST.n_err));
    e = HOST.n_err;
    wr(IDX_PROF0_DUR, DUR_MIN);
    chk("halted", 16'(e + 1), 16'(HOST.n_err));
    end_of_test();
  end
endmodule
`default_nettype wire
